/* rtl/rtc_config_bank.sv */
// Reference select and test-level configuration registers on AHB-Lite.
// Assumes a single bus master doing single word transfers and one clock.
//
// Notes on behaviour
// - Reference select at index 0Fh, resets zero.
// - Bits 5:3 pick the positive reference.
// - Bits 2:0 pick the negative reference.
// - Reserved bits read zero, ignore writes.
// - Positive level register at 10h, resets zero.
// - Bit 7 connects positive level to pin.
// - Bits 4:0 select positive output level.
// - Negative level register at 11h, resets zero.
// - Bit 7 connects negative level to pin.
// - Negative level uses the same coding.
// - Logic only forwards the selected code.
//
// Implementation choice: register access over AHB-Lite.
`timescale 1ns/1ps
module rtc_config_bank
  import rtc_pkg::*;
(
  // Clock and reset.
  input wire logic I_CLK_SYS,
  input wire logic I_RST_N,
  // AHB-Lite slave.
  input wire logic I_HSEL,
  input wire logic [31:0] I_HADDR,
  input wire logic [1:0] I_HTRANS,
  input wire logic I_HWRITE,
  input wire logic [2:0] I_HSIZE,
  input wire logic [31:0] I_HWDATA,
  input wire logic I_HREADY,
  output logic [31:0] O_HRDATA,
  output logic O_HREADYOUT,
  output logic O_HRESP,
  // Reference multiplexer selects, one-hot.
  output logic [4:0] O_REF_POS_SEL,
  output logic [4:0] O_REF_NEG_SEL,
  // Test-level generators.
  output logic O_POS_LEVEL_CONNECT,
  output logic [4:0] O_POS_LEVEL_CODE,
  output logic O_NEG_LEVEL_CONNECT,
  output logic [4:0] O_NEG_LEVEL_CODE
);

  // ----------------------------------------------------------------
  // Helpers.
  // ----------------------------------------------------------------
  function automatic logic addr_hit(input logic [31:0] addr, input logic [7:0] idx);
    return (addr[11:2] == {2'b00, idx}) && (addr[1:0] == 2'b00);
  endfunction

  function automatic logic level_reserved(input logic [4:0] code);
    return (code > LEVEL_UP_MAX) && ((code < LEVEL_DN_MIN) || (code > LEVEL_DN_MAX));
  endfunction

  // ----------------------------------------------------------------
  // Storage.
  // ----------------------------------------------------------------
  logic [7:0] reference_input_select;
  logic [7:0] test_level_pos_ctrl;
  logic [7:0] test_level_neg_ctrl;
  logic [3:0] status;
  logic wr_pend;
  logic [31:0] wr_addr;
  logic rd_pend;
  logic [31:0] rd_addr;
  logic accept;
  logic [7:0] wr_byte;
  logic [2:0] ref_pos_source;
  logic [2:0] ref_neg_source;
  logic [7:0] next_rdata;

  assign accept = I_HSEL && (I_HTRANS == HTRANS_NONSEQ) && I_HREADY;
  assign wr_byte = I_HWDATA[7:0];
  assign ref_pos_source = reference_input_select[REF_POS_LSB +: 3];
  assign ref_neg_source = reference_input_select[REF_NEG_LSB +: 3];

  // ----------------------------------------------------------------
  // Bus address phase.
  // ----------------------------------------------------------------
  // Narrow writes are dropped so that a stray byte store cannot
  // half-program a level; the bus only issues whole words anyway.
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_N) begin
      wr_pend <= 1'b0;
      wr_addr <= 32'h0000_0000;
    end else begin
      wr_pend <= accept && I_HWRITE && (I_HSIZE == HSIZE_WORD);
      wr_addr <= I_HADDR;
    end
  end

  // Reads take one wait state so that a read right behind a write
  // returns the freshly written value.
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_N) begin
      rd_pend <= 1'b0;
      rd_addr <= 32'h0000_0000;
      O_HREADYOUT <= 1'b1;
      O_HRDATA <= 32'h0000_0000;
    end else if (accept && !I_HWRITE) begin
      rd_pend <= 1'b1;
      rd_addr <= I_HADDR;
      O_HREADYOUT <= 1'b0;
    end else if (rd_pend) begin
      rd_pend <= 1'b0;
      O_HREADYOUT <= 1'b1;
      O_HRDATA <= {24'h00_0000, next_rdata};
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_N) begin
      O_HRESP <= 1'b0;
    end else begin
      O_HRESP <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Read multiplexer.
  // ----------------------------------------------------------------
  always_comb begin
    if (addr_hit(rd_addr, REF_SEL_IDX)) begin
      next_rdata = reference_input_select;
    end else if (addr_hit(rd_addr, POS_LEVEL_IDX)) begin
      next_rdata = test_level_pos_ctrl;
    end else if (addr_hit(rd_addr, NEG_LEVEL_IDX)) begin
      next_rdata = test_level_neg_ctrl;
    end else if (addr_hit(rd_addr, STATUS_IDX)) begin
      next_rdata = {4'h0, status};
    end else begin
      next_rdata = 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers.
  // ----------------------------------------------------------------
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_N) begin
      reference_input_select <= REF_SEL_RESET;
    end else if (wr_pend && addr_hit(wr_addr, REF_SEL_IDX)) begin
      reference_input_select <= wr_byte & REF_WMASK;
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_N) begin
      test_level_pos_ctrl <= LEVEL_RESET;
    end else if (wr_pend && addr_hit(wr_addr, POS_LEVEL_IDX)) begin
      test_level_pos_ctrl <= wr_byte & LEVEL_WMASK;
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_N) begin
      test_level_neg_ctrl <= LEVEL_RESET;
    end else if (wr_pend && addr_hit(wr_addr, NEG_LEVEL_IDX)) begin
      test_level_neg_ctrl <= wr_byte & LEVEL_WMASK;
    end
  end

  // Reserved codes are flagged, never corrected: the generator gets
  // exactly what software stored.
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_N) begin
      status <= STATUS_RESET;
    end else begin
      status <= {ref_neg_source > REF_CODE_SUPPLY,
                 ref_pos_source > REF_CODE_SUPPLY,
                 level_reserved(test_level_neg_ctrl[CODE_LSB +: 5]),
                 level_reserved(test_level_pos_ctrl[CODE_LSB +: 5])};
    end
  end

  // ----------------------------------------------------------------
  // Analog-facing outputs.
  // ----------------------------------------------------------------
  rtc_ref_decode u_pos_decode (
    .i_clk(I_CLK_SYS),
    .i_rst_n(I_RST_N),
    .i_code(ref_pos_source),
    .o_sel(O_REF_POS_SEL)
  );

  rtc_ref_decode u_neg_decode (
    .i_clk(I_CLK_SYS),
    .i_rst_n(I_RST_N),
    .i_code(ref_neg_source),
    .o_sel(O_REF_NEG_SEL)
  );

  assign O_POS_LEVEL_CONNECT = test_level_pos_ctrl[CONNECT_BIT];
  assign O_POS_LEVEL_CODE = test_level_pos_ctrl[CODE_LSB +: 5];
  assign O_NEG_LEVEL_CONNECT = test_level_neg_ctrl[CONNECT_BIT];
  assign O_NEG_LEVEL_CODE = test_level_neg_ctrl[CODE_LSB +: 5];

  // ----------------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------------
  logic wr_ref;
  logic wr_pos;
  logic wr_neg;
  assign wr_ref = wr_pend && addr_hit(wr_addr, REF_SEL_IDX);
  assign wr_pos = wr_pend && addr_hit(wr_addr, POS_LEVEL_IDX);
  assign wr_neg = wr_pend && addr_hit(wr_addr, NEG_LEVEL_IDX);

  chk_ref_reset_zero: assert property (
    @(posedge I_CLK_SYS)
    $rose(I_RST_N) |-> (reference_input_select == 8'h00) && (O_REF_POS_SEL == SEL_INTERNAL))
    else $error("Reference select not zero after reset.");

  chk_level_reset_zero: assert property (
    @(posedge I_CLK_SYS)
    $rose(I_RST_N) |-> !O_POS_LEVEL_CONNECT && (O_POS_LEVEL_CODE == 5'h00))
    else $error("Positive level not cleared by reset.");

  chk_neg_reset_zero: assert property (
    @(posedge I_CLK_SYS)
    $rose(I_RST_N) |-> (test_level_neg_ctrl == 8'h00))
    else $error("Negative level not cleared by reset.");

  chk_pos_ref_decode: assert property (
    @(posedge I_CLK_SYS) disable iff (!I_RST_N)
    (ref_pos_source == REF_CODE_PIN_C) ##1 (ref_pos_source == REF_CODE_PIN_C)
    |-> O_REF_POS_SEL == SEL_PIN_C)
    else $error("Positive reference select wrong for third pin code.");

  chk_pos_ref_rsvd: assert property (
    @(posedge I_CLK_SYS) disable iff (!I_RST_N)
    (ref_pos_source > REF_CODE_SUPPLY) |=> (O_REF_POS_SEL == SEL_NONE))
    else $error("Reserved positive reference code selected a source.");

  chk_neg_ref_supply: assert property (
    @(posedge I_CLK_SYS) disable iff (!I_RST_N)
    wr_ref && (wr_byte[2:0] == REF_CODE_SUPPLY) |=> ##1 (O_REF_NEG_SEL == SEL_SUPPLY))
    else $error("Negative reference does not reach supply two cycles after write.");

  chk_rsvd_bits_zero: assert property (
    @(posedge I_CLK_SYS) disable iff (!I_RST_N)
    (reference_input_select[7:6] == 2'b00) && (test_level_pos_ctrl[6:5] == 2'b00)
    && (test_level_neg_ctrl[6:5] == 2'b00))
    else $error("Reserved bits hold a one.");

  chk_pos_connect_wr: assert property (
    @(posedge I_CLK_SYS) disable iff (!I_RST_N)
    wr_pos |=> (O_POS_LEVEL_CONNECT == $past(I_HWDATA[7])))
    else $error("Positive connect does not follow the written bit.");

  chk_pos_code_wr: assert property (
    @(posedge I_CLK_SYS) disable iff (!I_RST_N)
    wr_pos |=> (O_POS_LEVEL_CODE == $past(I_HWDATA[4:0])))
    else $error("Positive level code does not follow the written field.");

  chk_neg_fields_wr: assert property (
    @(posedge I_CLK_SYS) disable iff (!I_RST_N)
    wr_neg |=> (O_NEG_LEVEL_CONNECT == $past(I_HWDATA[7]))
    && (O_NEG_LEVEL_CODE == $past(I_HWDATA[4:0])))
    else $error("Negative level fields do not follow the write.");

  chk_neg_rsvd_flag: assert property (
    @(posedge I_CLK_SYS) disable iff (!I_RST_N)
    (ref_neg_source > REF_CODE_SUPPLY) |=> status[3])
    else $error("Reserved negative reference code not flagged in status.");

  chk_hold_no_write: assert property (
    @(posedge I_CLK_SYS) disable iff (!I_RST_N)
    !wr_pos && !wr_neg |=> $stable(test_level_pos_ctrl) && $stable(test_level_neg_ctrl))
    else $error("Level register changed without a write.");

  chk_read_data: assert property (
    @(posedge I_CLK_SYS) disable iff (!I_RST_N)
    accept && !I_HWRITE && addr_hit(I_HADDR, POS_LEVEL_IDX) && !wr_pend
    |=> !O_HREADYOUT ##1 O_HREADYOUT && (O_HRDATA == {24'h00_0000, test_level_pos_ctrl}))
    else $error("Read of positive level returned wrong data or timing.");

  // ----------------------------------------------------------------
  // Decoder, bus timing and status checks.
  // ----------------------------------------------------------------
  chk_pos_ref_internal: assert property (
    @(posedge I_CLK_SYS) disable iff (!I_RST_N)
    (ref_pos_source == REF_CODE_INTERNAL) |=> (O_REF_POS_SEL == SEL_INTERNAL))
    else $error("Positive reference does not select the internal source.");

  chk_pos_ref_supply: assert property (
    @(posedge I_CLK_SYS) disable iff (!I_RST_N)
    (ref_pos_source == REF_CODE_SUPPLY) |=> (O_REF_POS_SEL == SEL_SUPPLY))
    else $error("Positive reference does not select the supply.");

  chk_pos_rsvd_flag: assert property (
    @(posedge I_CLK_SYS) disable iff (!I_RST_N)
    (ref_pos_source > REF_CODE_SUPPLY) |=> status[2])
    else $error("Reserved positive reference code not flagged in status.");

  chk_neg_ref_pin: assert property (
    @(posedge I_CLK_SYS) disable iff (!I_RST_N)
    (ref_neg_source == REF_CODE_PIN_A) |=> (O_REF_NEG_SEL == SEL_PIN_A))
    else $error("Negative reference does not select the first pin.");

  chk_neg_ref_rsvd: assert property (
    @(posedge I_CLK_SYS) disable iff (!I_RST_N)
    (ref_neg_source > REF_CODE_SUPPLY) |=> (O_REF_NEG_SEL == SEL_NONE))
    else $error("Reserved negative reference code selected a source.");

  chk_ref_wr_mask: assert property (
    @(posedge I_CLK_SYS) disable iff (!I_RST_N)
    wr_ref |=> (reference_input_select == {2'b00, $past(I_HWDATA[5:0])}))
    else $error("Reference select does not hold the written fields only.");

  chk_wr_zero_wait: assert property (
    @(posedge I_CLK_SYS) disable iff (!I_RST_N)
    accept && I_HWRITE |=> O_HREADYOUT)
    else $error("Write data phase was stretched.");

  chk_rd_one_wait: assert property (
    @(posedge I_CLK_SYS) disable iff (!I_RST_N)
    accept && !I_HWRITE |=> !O_HREADYOUT ##1 O_HREADYOUT)
    else $error("Read data phase does not take exactly one wait state.");

  chk_narrow_wr_dropped: assert property (
    @(posedge I_CLK_SYS) disable iff (!I_RST_N)
    accept && I_HWRITE && (I_HSIZE != HSIZE_WORD) |=> ##1 $stable(reference_input_select)
    && $stable(test_level_pos_ctrl) && $stable(test_level_neg_ctrl))
    else $error("Narrow write changed a register.");

  cov_pos_connect: cover property (
    @(posedge I_CLK_SYS) disable iff (!I_RST_N) wr_pos && I_HWDATA[7]);

  cov_ref_read: cover property (
    @(posedge I_CLK_SYS) disable iff (!I_RST_N)
    accept && !I_HWRITE && addr_hit(I_HADDR, REF_SEL_IDX));

  cov_rsvd_code: cover property (
    @(posedge I_CLK_SYS) disable iff (!I_RST_N) status[3]);

  cov_write_then_read: cover property (
    @(posedge I_CLK_SYS) disable iff (!I_RST_N) wr_neg && accept && !I_HWRITE);

  cov_narrow_write: cover property (
    @(posedge I_CLK_SYS) disable iff (!I_RST_N) accept && I_HWRITE && (I_HSIZE != HSIZE_WORD));

endmodule

/* rtl/rtc_pkg.sv */
// Shared constants of the reference and test-level configuration bank.
// Assumes a 32-bit AHB-Lite bus with one word per register.
package rtc_pkg;

  // ----------------------------------------------------------------
  // Register indices; the byte address is four times the index.
  // ----------------------------------------------------------------
  localparam logic [7:0] REF_SEL_IDX = 8'h0F;
  localparam logic [7:0] POS_LEVEL_IDX = 8'h10;
  localparam logic [7:0] NEG_LEVEL_IDX = 8'h11;
  localparam logic [7:0] STATUS_IDX = 8'h20;

  // ----------------------------------------------------------------
  // Field positions, masks and reset values.
  // ----------------------------------------------------------------
  localparam int REF_POS_LSB = 3;
  localparam int REF_NEG_LSB = 0;
  localparam int CONNECT_BIT = 7;
  localparam int CODE_LSB = 0;
  localparam logic [7:0] REF_WMASK = 8'h3F;
  localparam logic [7:0] LEVEL_WMASK = 8'h9F;
  localparam logic [7:0] REF_SEL_RESET = 8'h00;
  localparam logic [7:0] LEVEL_RESET = 8'h00;
  localparam logic [3:0] STATUS_RESET = 4'h0;

  // ----------------------------------------------------------------
  // Reference source codes and one-hot select positions.
  // ----------------------------------------------------------------
  localparam logic [2:0] REF_CODE_INTERNAL = 3'h0;
  localparam logic [2:0] REF_CODE_PIN_A = 3'h1;
  localparam logic [2:0] REF_CODE_PIN_B = 3'h2;
  localparam logic [2:0] REF_CODE_PIN_C = 3'h3;
  localparam logic [2:0] REF_CODE_SUPPLY = 3'h4;
  localparam logic [4:0] SEL_NONE = 5'h00;
  localparam logic [4:0] SEL_INTERNAL = 5'h01;
  localparam logic [4:0] SEL_PIN_A = 5'h02;
  localparam logic [4:0] SEL_PIN_B = 5'h04;
  localparam logic [4:0] SEL_PIN_C = 5'h08;
  localparam logic [4:0] SEL_SUPPLY = 5'h10;

  // ----------------------------------------------------------------
  // Level code table limits and bus encodings.
  // ----------------------------------------------------------------
  localparam logic [4:0] LEVEL_UP_MAX = 5'h09;
  localparam logic [4:0] LEVEL_DN_MIN = 5'h11;
  localparam logic [4:0] LEVEL_DN_MAX = 5'h19;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

endpackage

/* rtl/rtc_ref_decode.sv */
// Registered decoder from a three-bit reference code to a one-hot select.
// Assumes the code comes from a register on the same clock.
`timescale 1ns/1ps
module rtc_ref_decode
  import rtc_pkg::*;
(
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Code in, select out.
  input wire logic [2:0] i_code,
  output logic [4:0] o_sel
);

  logic [4:0] next_sel;

  // Reserved codes open every switch rather than guess a source.
  always_comb begin
    case (i_code)
      REF_CODE_INTERNAL: next_sel = SEL_INTERNAL;
      REF_CODE_PIN_A: next_sel = SEL_PIN_A;
      REF_CODE_PIN_B: next_sel = SEL_PIN_B;
      REF_CODE_PIN_C: next_sel = SEL_PIN_C;
      REF_CODE_SUPPLY: next_sel = SEL_SUPPLY;
      default: next_sel = SEL_NONE;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_sel <= SEL_INTERNAL;
    end else begin
      o_sel <= next_sel;
    end
  end

endmodule

/* dv/tb_rtc_config_bank.sv */
// Self-checking bench for the reference select and test-level configuration bank.
// Assumes one AHB-Lite master (this bench), hready fed back from the slave, one clock.
`timescale 1ns/1ps
`define CHK(act, exp) begin n_compared++; if ((act) !== (exp)) begin err_total++; \
  $display("MISMATCH %0t got %h expected %h", $time, act, exp); end end
module tb_rtc_config_bank;
  import rtc_pkg::*;

  // ----------------------------------------------------------------
  // Stimulus and observed signals.
  // ----------------------------------------------------------------
  localparam logic [31:0] A_REF = {22'h0, REF_SEL_IDX, 2'b00};
  localparam logic [31:0] A_POS = {22'h0, POS_LEVEL_IDX, 2'b00};
  localparam logic [31:0] A_NEG = {22'h0, NEG_LEVEL_IDX, 2'b00};
  localparam logic [31:0] A_FREE = 32'h00000048;
  localparam logic [31:0] A_STAT = {22'h0, STATUS_IDX, 2'b00};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = HSIZE_WORD;
  logic [31:0] hwdata = 32'h0;
  wire logic [31:0] hrdata;
  wire logic hreadyout;
  wire logic hresp;
  wire logic [4:0] ref_pos_sel;
  wire logic [4:0] ref_neg_sel;
  wire logic pos_conn;
  wire logic [4:0] pos_code;
  wire logic neg_conn;
  wire logic [4:0] neg_code;
  int err_total = 0;
  int n_compared = 0;
  int cycles = 0;

  rtc_config_bank rtc_config_bank_inst (
    .I_CLK_SYS(clk), .I_RST_N(rst_n), .I_HSEL(hsel), .I_HADDR(haddr),
    .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(hsize), .I_HWDATA(hwdata),
    .I_HREADY(hreadyout), .O_HRDATA(hrdata), .O_HREADYOUT(hreadyout), .O_HRESP(hresp),
    .O_REF_POS_SEL(ref_pos_sel), .O_REF_NEG_SEL(ref_neg_sel),
    .O_POS_LEVEL_CONNECT(pos_conn), .O_POS_LEVEL_CODE(pos_code),
    .O_NEG_LEVEL_CONNECT(neg_conn), .O_NEG_LEVEL_CODE(neg_code)
  );

  always #5 clk = ~clk;

  // A hung handshake would stall the sequence, so the run is capped here.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      $display("MISMATCH %0t run did not finish in time", $time);
      test_done();
    end
  end

  // ----------------------------------------------------------------
  // Bus tasks and expectations.
  // ----------------------------------------------------------------
  task test_done;
    if (err_total == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // One single transfer; waits on hready for as long as the slave needs it.
  task automatic xfer(input logic wr, input logic [31:0] addr, input logic [2:0] sz,
                      input logic [31:0] wdata, output logic [31:0] rdata);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= addr;
    hwrite <= wr;
    hsize <= sz;
    do begin @(posedge clk); end while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wdata;
    do begin @(posedge clk); end while (hreadyout !== 1'b1);
    rdata = hrdata;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] x;
    xfer(1'b1, a, HSIZE_WORD, d, x);
  endtask

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] x;
    xfer(1'b0, a, HSIZE_WORD, 32'h0, x);
    `CHK(x, e)
    `CHK(hresp, 1'b0)
  endtask

  function automatic logic [4:0] exp_sel(input logic [2:0] c);
    case (c)
      REF_CODE_INTERNAL: return SEL_INTERNAL;
      REF_CODE_PIN_A: return SEL_PIN_A;
      REF_CODE_PIN_B: return SEL_PIN_B;
      REF_CODE_PIN_C: return SEL_PIN_C;
      REF_CODE_SUPPLY: return SEL_SUPPLY;
      default: return SEL_NONE;
    endcase
  endfunction

  task automatic chk_ref(input logic [2:0] p, input logic [2:0] n);
    #1;
    `CHK(ref_pos_sel, exp_sel(p))
    `CHK(ref_neg_sel, exp_sel(n))
  endtask

  // Reset pulse of ten cycles, then the three registers and level outputs at zero, both reference selects on the internal source.
  task automatic reset_chk;
    rst_n <= 1'b0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk(A_REF, 32'h0);
    rd_chk(A_POS, 32'h0);
    rd_chk(A_NEG, 32'h0);
    chk_ref(3'h0, 3'h0);
    `CHK({pos_conn, pos_code, neg_conn, neg_code}, 12'h000)
  endtask

  // ----------------------------------------------------------------
  // Test sequence.
  // ----------------------------------------------------------------
  initial begin
    logic [2:0] p;
    logic [2:0] n;
    logic [4:0] c;
    logic [31:0] x;
    reset_chk();
    // Every reference code on both sides, reserved bits and upper bus bits set.
    for (int i = 0; i < 8; i++) begin
      p = 3'(i);
      n = 3'(i + 3);
      wr(A_REF, {24'hFFFFFF, 2'b11, p, n});
      rd_chk(A_REF, {26'h0, p, n});
      rd_chk(A_STAT, {28'h0, n > 3'h4, p > 3'h4, 2'b00});
      chk_ref(p, n);
    end
    // Only the documented level codes are used; connect bits run opposite.
    for (int j = 0; j < 19; j++) begin
      c = (j < 10) ? 5'(j) : 5'(j + 7);
      wr(A_POS, {24'hFFFFFF, j[0], 2'b11, c});
      wr(A_NEG, {24'hFFFFFF, ~j[0], 2'b11, c});
      rd_chk(A_POS, {24'h0, j[0], 2'b00, c});
      rd_chk(A_NEG, {24'h0, ~j[0], 2'b00, c});
      #1;
      `CHK(pos_conn, j[0])
      `CHK(pos_code, c)
      `CHK(neg_conn, ~j[0])
      `CHK(neg_code, c)
    end
    // A byte-wide write is dropped and an unmapped write touches nothing.
    xfer(1'b1, A_POS, 3'h0, 32'h00000085, x);
    rd_chk(A_POS, 32'h00000019);
    wr(A_FREE, 32'hFFFFFFFF);
    rd_chk(A_FREE, 32'h0);
    rd_chk(A_NEG, 32'h00000099);
    reset_chk();
    test_done();
  end
endmodule
